// *** core/flash_protect.v ***
// serial flash write-protection: latch, protect levels, locks, secured area
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "flash_protect_defines.vh"
module flash_protect #(
   parameter [7:0] OP_SET_LATCH = 8'h06,
   parameter [7:0] OP_CLR_LATCH = 8'h04,
   parameter [7:0] OP_STATUS_WR = 8'h01,
   parameter [7:0] OP_QUAD_PROG = 8'h38,
   parameter [7:0] OP_SECTOR_ERASE = 8'h20,
   parameter [7:0] OP_BLOCK32_ERASE = 8'h52,
   parameter [7:0] OP_PAGE_PROG = 8'h12,
   parameter [7:0] OP_CONT_PROG = 8'h13,
   parameter [7:0] OP_BLOCK64_ERASE = 8'h14,
   parameter [7:0] OP_CHIP_ERASE = 8'h15,
   parameter [7:0] OP_SINGLE_LOCK = 8'h16,
   parameter [7:0] OP_SINGLE_UNLOCK = 8'h17,
   parameter [7:0] OP_CHIP_LOCK = 8'h18,
   parameter [7:0] OP_CHIP_UNLOCK = 8'h19,
   parameter [7:0] OP_LOCK_MODE = 8'h1A,
   parameter [7:0] OP_ENTER_SECURED = 8'h1B,
   parameter [7:0] OP_EXIT_SECURED = 8'h1C,
   parameter [7:0] OP_SECURITY_WR = 8'h1D,
   parameter [7:0] OP_SLEEP = 8'h1E,
   parameter [7:0] OP_WAKE = 8'h1F,
   parameter [7:0] OP_SIGNATURE = 8'h21
) (
   input wire I_CLK,
   input wire I_RST_B,
   input wire I_SCLK,
   input wire I_CS_B,
   input wire I_SI,
   input wire I_WP_B,
   input wire [1:0] I_ADDR,
   input wire [7:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   output reg [7:0] O_RDATA,
   output reg O_WRITE_ENABLE_LATCH,
   output reg O_OP_VALID,
   output reg [7:0] O_OP_CODE,
   output reg [23:0] O_OP_ADDR,
   output reg [7:0] O_OP_DATA,
   output reg O_OP_OTP,
   output reg O_REJECT
);

   // =====================================================
   // pin synchronisers and edge detection
   wire [3:0] pins_s;
   wire sclk_s = pins_s[0];
   wire cs_b_s = pins_s[1];
   wire si_s = pins_s[2];
   wire wp_b_s = pins_s[3];
   reg sclk_d_r;
   reg cs_b_d_r;

   pin_sync #(.W(4), .RST_VAL(4'hA)) pin_sync_inst (
      .i_clk(I_CLK),
      .i_rst_b(I_RST_B),
      .i_d({I_WP_B, I_SI, I_CS_B, I_SCLK}),
      .o_q(pins_s)
   );

   wire sclk_rise = sclk_s & ~sclk_d_r & ~cs_b_s;
   wire cs_rise = cs_b_s & ~cs_b_d_r;
   wire cs_fall = ~cs_b_s & cs_b_d_r;

   // =====================================================
   // serial byte assembly
   reg [6:0] shift_r;
   reg [2:0] bit_cnt_r;
   reg [2:0] byte_cnt_r;
   reg [7:0] cmd_r;
   reg [23:0] addr_r;
   reg [7:0] data_r;
   wire [7:0] byte_nxt = {shift_r, si_s};

   always @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         sclk_d_r <= 1'b0;
         cs_b_d_r <= 1'b1;
         shift_r <= 7'h00;
         bit_cnt_r <= 3'h0;
         byte_cnt_r <= 3'h0;
         cmd_r <= 8'h00;
         addr_r <= 24'h000000;
         data_r <= 8'h00;
      end else begin
         sclk_d_r <= sclk_s;
         cs_b_d_r <= cs_b_s;
         if (cs_fall) begin
            bit_cnt_r <= 3'h0;
            byte_cnt_r <= 3'h0;
         end else if (sclk_rise) begin
            shift_r <= byte_nxt[6:0];
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
               if (byte_cnt_r != 3'h7) begin
                  byte_cnt_r <= byte_cnt_r + 3'h1;
               end
               if (byte_cnt_r == 3'h0) begin
                  cmd_r <= byte_nxt;
               end else if (byte_cnt_r < `ADDR_BYTES) begin
                  addr_r <= {addr_r[15:0], byte_nxt};
               end else if (byte_cnt_r == `ADDR_BYTES) begin
                  data_r <= byte_nxt;
               end
            end
         end
      end
   end

   // =====================================================
   // protection state
   reg write_enable_latch_r;
   reg [3:0] bp_r;
   reg status_write_disable_r;
   reg quad_r;
   reg dpd_r;
   reg secured_r;
   reg lock_mode_r;
   reg factory_lock_r;
   reg cust_lock_r;
   reg [255:0] blk_lock_r;
   reg [15:0] sec_lo_r;
   reg [15:0] sec_hi_r;
   reg [7:0] last_cmd_r;

   // guard pin only counts while not used as a data lane
   wire hw_lock = status_write_disable_r & ~wp_b_s & ~quad_r;
   wire addr_ok = (byte_cnt_r >= `ADDR_BYTES);
   wire any_lock = (|blk_lock_r) | (|sec_lo_r) | (|sec_hi_r);

   // protect-level decode for one 64K block
   function bp_hit;
      input [7:0] blk;
      input [3:0] bp;
      begin
         if (bp[3]) begin
            bp_hit = 1'b1;
         end else if (bp[2:0] == 3'h0) begin
            bp_hit = 1'b0;
         end else begin
            bp_hit = ({1'b0, blk} >= (9'h100 - (9'h001 << bp[2:0])));
         end
      end
   endfunction

   // individual lock lookup over the span touched by an operation
   function lock_hit;
      input [23:0] a;
      input [1:0] span;
      reg [15:0] secs;
      reg [15:0] mask;
      begin
         secs = (a[23:16] == `BOT_BLOCK) ? sec_lo_r : sec_hi_r;
         mask = 16'h0000;
         if (span == `SPAN_64K) begin
            mask = 16'hFFFF;
         end else if (span == `SPAN_32K) begin
            mask = a[15] ? 16'hFF00 : 16'h00FF;
         end else begin
            mask = 16'h0001 << a[15:12];
         end
         if (a[23:16] == `BOT_BLOCK || a[23:16] == `TOP_BLOCK) begin
            lock_hit = |(secs & mask);
         end else begin
            lock_hit = blk_lock_r[a[23:16]];
         end
      end
   endfunction

   // individual locks replace protect levels only in lock mode
   function prot_hit;
      input [23:0] a;
      input [1:0] span;
      begin
         if (lock_mode_r) begin
            prot_hit = lock_hit(a, span);
         end else begin
            prot_hit = bp_hit(a[23:16], bp_r);
         end
      end
   endfunction

   // =====================================================
   // command classification
   wire is_prog = (cmd_r == OP_PAGE_PROG) | (cmd_r == OP_QUAD_PROG) |
      (cmd_r == OP_CONT_PROG);
   wire is_erase = (cmd_r == OP_SECTOR_ERASE) | (cmd_r == OP_BLOCK32_ERASE) |
      (cmd_r == OP_BLOCK64_ERASE);
   wire [1:0] span = (cmd_r == OP_BLOCK64_ERASE) ? `SPAN_64K :
      (cmd_r == OP_BLOCK32_ERASE) ? `SPAN_32K : `SPAN_4K;
   wire is_single = (cmd_r == OP_SINGLE_LOCK) | (cmd_r == OP_SINGLE_UNLOCK);
   wire lock_val = (cmd_r == OP_SINGLE_LOCK);
   wire edge_blk = (addr_r[23:16] == `BOT_BLOCK) | (addr_r[23:16] == `TOP_BLOCK);

   // =====================================================
   // command execution at end of frame
   always @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         write_enable_latch_r <= 1'b0;
         bp_r <= 4'h0;
         status_write_disable_r <= 1'b0;
         quad_r <= 1'b0;
         dpd_r <= 1'b0;
         secured_r <= 1'b0;
         lock_mode_r <= 1'b0;
         factory_lock_r <= 1'b0;
         cust_lock_r <= 1'b0;
         blk_lock_r <= {256{1'b0}};
         sec_lo_r <= 16'h0000;
         sec_hi_r <= 16'h0000;
         last_cmd_r <= 8'h00;
         O_OP_VALID <= 1'b0;
         O_OP_CODE <= 8'h00;
         O_OP_ADDR <= 24'h000000;
         O_OP_DATA <= 8'h00;
         O_OP_OTP <= 1'b0;
         O_REJECT <= 1'b0;
      end else begin
         O_OP_VALID <= 1'b0;
         O_REJECT <= 1'b0;
         // one-time straps from the register port
         if (I_WR && I_ADDR == `REG_CONTROL) begin
            if (I_WDATA[`CTL_FACTORY]) begin
               factory_lock_r <= 1'b1;
            end
            if (I_WDATA[`CTL_LOCKSEL]) begin
               lock_mode_r <= 1'b1;
            end
         end
         if (cs_rise) begin
            if (bit_cnt_r != 3'h0 || byte_cnt_r == 3'h0) begin
               O_REJECT <= 1'b1;
            end else if (dpd_r && cmd_r != OP_WAKE && cmd_r != OP_SIGNATURE) begin
               O_REJECT <= 1'b1;
            end else begin
               last_cmd_r <= cmd_r;
               if (cmd_r == OP_SET_LATCH) begin
                  write_enable_latch_r <= 1'b1;
               end else if (cmd_r == OP_CLR_LATCH) begin
                  write_enable_latch_r <= 1'b0;
               end else if (cmd_r == OP_STATUS_WR) begin
                  if (write_enable_latch_r && byte_cnt_r >= 3'h2) begin
                     quad_r <= addr_r[`ST_QUAD];
                     if (!hw_lock) begin
                        bp_r <= addr_r[`ST_BP_HI:`ST_BP_LO];
                        status_write_disable_r <= addr_r[`ST_WR_DISABLE];
                     end
                  end else begin
                     O_REJECT <= 1'b1;
                  end
                  write_enable_latch_r <= 1'b0;
               end else if (is_prog || is_erase) begin
                  write_enable_latch_r <= 1'b0;
                  if (!write_enable_latch_r || !addr_ok) begin
                     O_REJECT <= 1'b1;
                  end else if (secured_r) begin
                     // serial number words and locked area stay fixed
                     if (is_erase || factory_lock_r || cust_lock_r ||
                         addr_r[8:0] <= `SERIAL_LAST) begin
                        O_REJECT <= 1'b1;
                     end else begin
                        O_OP_VALID <= 1'b1;
                        O_OP_OTP <= 1'b1;
                        O_OP_CODE <= cmd_r;
                        O_OP_ADDR <= {15'h0000, addr_r[8:0]};
                        O_OP_DATA <= data_r;
                     end
                  end else if (prot_hit(addr_r, span)) begin
                     O_REJECT <= 1'b1;
                  end else begin
                     O_OP_VALID <= 1'b1;
                     O_OP_OTP <= 1'b0;
                     O_OP_CODE <= cmd_r;
                     O_OP_ADDR <= addr_r;
                     O_OP_DATA <= data_r;
                  end
               end else if (cmd_r == OP_CHIP_ERASE) begin
                  write_enable_latch_r <= 1'b0;
                  if (write_enable_latch_r && bp_r == 4'h0 && !secured_r &&
                      !(lock_mode_r && any_lock)) begin
                     O_OP_VALID <= 1'b1;
                     O_OP_OTP <= 1'b0;
                     O_OP_CODE <= cmd_r;
                     O_OP_ADDR <= 24'h000000;
                     O_OP_DATA <= 8'h00;
                  end else begin
                     O_REJECT <= 1'b1;
                  end
               end else if (is_single) begin
                  write_enable_latch_r <= 1'b0;
                  if (!write_enable_latch_r || !lock_mode_r || !addr_ok) begin
                     O_REJECT <= 1'b1;
                  end else if (edge_blk && addr_r[23:16] == `BOT_BLOCK) begin
                     sec_lo_r[addr_r[15:12]] <= lock_val;
                  end else if (edge_blk) begin
                     sec_hi_r[addr_r[15:12]] <= lock_val;
                  end else begin
                     blk_lock_r[addr_r[23:16]] <= lock_val;
                  end
               end else if (cmd_r == OP_CHIP_LOCK || cmd_r == OP_CHIP_UNLOCK) begin
                  write_enable_latch_r <= 1'b0;
                  if (write_enable_latch_r && lock_mode_r) begin
                     blk_lock_r <= {256{cmd_r == OP_CHIP_LOCK}};
                     sec_lo_r <= {16{cmd_r == OP_CHIP_LOCK}};
                     sec_hi_r <= {16{cmd_r == OP_CHIP_LOCK}};
                  end else begin
                     O_REJECT <= 1'b1;
                  end
               end else if (cmd_r == OP_LOCK_MODE) begin
                  if (write_enable_latch_r) begin
                     lock_mode_r <= 1'b1;
                  end else begin
                     O_REJECT <= 1'b1;
                  end
               end else if (cmd_r == OP_ENTER_SECURED) begin
                  secured_r <= 1'b1;
               end else if (cmd_r == OP_EXIT_SECURED) begin
                  secured_r <= 1'b0;
               end else if (cmd_r == OP_SECURITY_WR) begin
                  write_enable_latch_r <= 1'b0;
                  if (write_enable_latch_r) begin
                     cust_lock_r <= 1'b1;
                  end else begin
                     O_REJECT <= 1'b1;
                  end
               end else if (cmd_r == OP_SLEEP) begin
                  dpd_r <= 1'b1;
               end else if (cmd_r == OP_WAKE || cmd_r == OP_SIGNATURE) begin
                  dpd_r <= 1'b0;
               end else begin
                  O_REJECT <= 1'b1;
               end
            end
         end
      end
   end

   // =====================================================
   // register port readback, data valid one cycle after the strobe
   always @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_RDATA <= 8'h00;
         O_WRITE_ENABLE_LATCH <= 1'b0;
      end else begin
         O_WRITE_ENABLE_LATCH <= write_enable_latch_r;
         O_RDATA <= 8'h00;
         if (I_RD) begin
            case (I_ADDR)
               `REG_STATUS: begin
                  O_RDATA <= {status_write_disable_r, quad_r, bp_r, write_enable_latch_r, 1'b0};
               end
               `REG_MODE: begin
                  O_RDATA <= {5'h00, lock_mode_r, secured_r, dpd_r};
               end
               `REG_SECURITY: begin
                  O_RDATA <= {6'h00, cust_lock_r, factory_lock_r};
               end
               `REG_CONTROL: begin
                  O_RDATA <= last_cmd_r;
               end
               default: begin
                  O_RDATA <= 8'h00;
               end
            endcase
         end
      end
   end
endmodule

// *** core/flash_protect_defines.vh ***
// constants for the serial flash write-protection block
`ifndef FLASH_PROTECT_DEFINES_VH
`define FLASH_PROTECT_DEFINES_VH

// =====================================================
// register port offsets
`define REG_STATUS 2'h0
`define REG_MODE 2'h1
`define REG_SECURITY 2'h2
`define REG_CONTROL 2'h3

// =====================================================
// status byte layout (status write data and status readback)
`define ST_WR_DISABLE 7
`define ST_QUAD 6
`define ST_BP_HI 5
`define ST_BP_LO 2
`define ST_LATCH 1

// =====================================================
// mode, security and control bit positions
`define MODE_DPD 0
`define MODE_SECURED 1
`define MODE_LOCKSEL 2
`define SEC_FACTORY 0
`define SEC_CUSTOMER 1
`define CTL_FACTORY 0
`define CTL_LOCKSEL 1

// =====================================================
// array geometry and erase spans
`define TOP_BLOCK 8'hFF
`define BOT_BLOCK 8'h00
`define SPAN_4K 2'h0
`define SPAN_32K 2'h1
`define SPAN_64K 2'h2
`define ADDR_BYTES 3'h4
`define SERIAL_LAST 9'h00F

`endif

// *** core/pin_sync.v ***
// two-flop synchroniser for pins entering the core clock domain
`timescale 1ns/10ps
module pin_sync #(
   parameter W = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input wire i_clk,
   input wire i_rst_b,
   input wire [W-1:0] i_d,
   output wire [W-1:0] o_q
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
      end else begin
         s1_r <= i_d;
         s2_r <= s1_r;
      end
   end

   assign o_q = s2_r;
endmodule

// *** test/flash_protect_sva.sv ***
// port checker for the write-protection block
`timescale 1ns/10ps
module flash_protect_chk (
   input wire I_CLK,
   input wire I_RST_B,
   input wire I_CS_B,
   input wire [1:0] I_ADDR,
   input wire [7:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   input wire [7:0] O_RDATA,
   input wire O_WRITE_ENABLE_LATCH,
   input wire O_OP_VALID,
   input wire O_REJECT
);
   // =====================================
   // lock bits known to be set so far
   reg [1:0] seen_r;
   reg rd_sec_r;
   always @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         seen_r <= 2'h0;
         rd_sec_r <= 1'b0;
      end else begin
         rd_sec_r <= I_RD && I_ADDR == 2'h2;
         seen_r <= seen_r | (rd_sec_r ? O_RDATA[1:0] : 2'h0)
            | ((I_WR && I_ADDR == 2'h3) ? {1'b0, I_WDATA[0]} : 2'h0);
      end
   end
   // =====================================
   // properties
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);
   AST_RESET_IDLE: assert property ($rose(I_RST_B) |->
      !O_WRITE_ENABLE_LATCH && !O_OP_VALID) else $error("outputs busy after reset");
   AST_OP_NEEDS_LATCH: assert property (O_OP_VALID |-> O_WRITE_ENABLE_LATCH)
      else $error("operation without latch");
   AST_LATCH_FROM_FRAME: assert property ($rose(O_WRITE_ENABLE_LATCH) |->
      $past(I_CS_B, 3)) else $error("latch set outside frame end");
   AST_OP_CLEARS_LATCH: assert property (O_OP_VALID |=> !O_WRITE_ENABLE_LATCH)
      else $error("latch kept after operation");
   AST_RESULT_AT_END: assert property ((O_OP_VALID || O_REJECT) |-> $past(I_CS_B, 2))
      else $error("result while selected");
   AST_STATUS_LATCH: assert property ($past(I_RD) && $past(I_ADDR) == 2'h0 |->
      O_RDATA[1] == O_WRITE_ENABLE_LATCH && !O_RDATA[0])
      else $error("status latch bit wrong");
   AST_NO_DOUBLE: assert property (!(O_OP_VALID && O_REJECT))
      else $error("operation both run and refused");
   AST_LOCK_STICKY: assert property (rd_sec_r |-> (O_RDATA[1:0] & seen_r) == seen_r)
      else $error("lock bit cleared");
   cover property (O_OP_VALID);
   cover property (O_REJECT);
   cover property ($rose(O_WRITE_ENABLE_LATCH));
endmodule
bind flash_protect flash_protect_chk flash_protect_chk_inst (
   .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_CS_B(I_CS_B), .I_ADDR(I_ADDR),
   .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
   .O_WRITE_ENABLE_LATCH(O_WRITE_ENABLE_LATCH),
   .O_OP_VALID(O_OP_VALID), .O_REJECT(O_REJECT)
);

// *** test/spi_host_model.sv ***
// serial host model: sends one frame of up to five bytes, mode 0
`timescale 1ns/10ps
module spi_host_model (
   input wire i_clk,
   input wire i_go,
   input wire [39:0] i_data,
   input wire [5:0] i_nbits,
   output reg o_busy,
   output reg o_sclk,
   output reg o_cs_b,
   output reg o_si
);
   integer i;
   initial begin
      o_busy = 1'b0;
      o_sclk = 1'b0;
      o_cs_b = 1'b1;
      o_si = 1'b0;
      forever begin
         @(posedge i_clk);
         if (i_go) begin
            o_busy <= 1'b1;
            o_cs_b <= 1'b0;
            for (i = 0; i < i_nbits; i = i + 1) begin
               o_si <= i_data[39 - i];
               repeat (4) @(posedge i_clk);
               o_sclk <= 1'b1;
               repeat (4) @(posedge i_clk);
               o_sclk <= 1'b0;
            end
            repeat (4) @(posedge i_clk);
            o_cs_b <= 1'b1;
            o_si <= ~o_si;
            o_busy <= 1'b0;
         end
      end
   end
endmodule

// *** test/test_flash_protect.sv ***
// bench for the write-protection block
`timescale 1ns/10ps
module test_flash_protect;
   localparam N1 = 6'h08, N2 = 6'h10, N4 = 6'h20, N5 = 6'h28;
   localparam ACC = 2'h0, RUN = 2'h1, REF = 2'h2, ANY = 2'h3;
   reg I_CLK, I_RST_B, I_WP_B, I_WR, I_RD, go;
   reg [1:0] I_ADDR;
   reg [7:0] I_WDATA;
   reg [39:0] frm;
   reg [5:0] nb;
   reg [47:0] ops = 48'h3813_2052_1415;
   wire I_SCLK, I_CS_B, I_SI, busy, O_WRITE_ENABLE_LATCH, O_OP_VALID, O_OP_OTP, O_REJECT;
   wire [7:0] O_RDATA, O_OP_CODE, O_OP_DATA;
   wire [23:0] O_OP_ADDR;
   integer num_errors = 0;
   integer samples_checked = 0;
   integer cyc = 0;
   integer k;
   flash_protect flash_protect_inst (
      .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_SCLK(I_SCLK), .I_CS_B(I_CS_B),
      .I_SI(I_SI), .I_WP_B(I_WP_B), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
      .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
      .O_WRITE_ENABLE_LATCH(O_WRITE_ENABLE_LATCH),
      .O_OP_VALID(O_OP_VALID), .O_OP_CODE(O_OP_CODE), .O_OP_ADDR(O_OP_ADDR),
      .O_OP_DATA(O_OP_DATA), .O_OP_OTP(O_OP_OTP), .O_REJECT(O_REJECT)
   );
   spi_host_model spi_host_model_inst (
      .i_clk(I_CLK), .i_go(go), .i_data(frm), .i_nbits(nb), .o_busy(busy),
      .o_sclk(I_SCLK), .o_cs_b(I_CS_B), .o_si(I_SI)
   );
   initial begin
      I_CLK = 1'b0;
      forever #10 I_CLK = ~I_CLK;
   end
   always @(posedge I_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         num_errors = num_errors + 1;
         wrap_up;
      end
   end
   // =====================================
   // tasks
   task wrap_up;
      begin
         if (num_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
         end else begin
            $display("*** FAIL ***");
         end
         $finish;
      end
   endtask
   task chk(input [31:0] s, input [31:0] x);
      begin
         samples_checked = samples_checked + 1;
         if (s !== x) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
         end
      end
   endtask
   task wr(input [1:0] a, input [7:0] d);
      begin
         @(posedge I_CLK);
         I_WR <= 1'b1;
         I_ADDR <= a;
         I_WDATA <= d;
         @(posedge I_CLK);
         I_WR <= 1'b0;
      end
   endtask
   task rdc(input [1:0] a, input [7:0] x);
      begin
         @(posedge I_CLK);
         I_RD <= 1'b1;
         I_ADDR <= a;
         @(posedge I_CLK);
         I_RD <= 1'b0;
         @(negedge I_CLK);
         chk(O_RDATA, x);
         @(posedge I_CLK);
      end
   endtask
   // one frame, then result pulses gathered: bit1 refused, bit0 run
   task f(input [7:0] op, input [23:0] ad, input [7:0] dt, input [5:0] n, input [1:0] e);
      reg [1:0] got;
      begin
         @(posedge I_CLK);
         frm <= {op, ad, dt};
         nb <= n;
         go <= 1'b1;
         @(posedge I_CLK);
         go <= 1'b0;
         @(posedge I_CLK);
         while (busy) @(posedge I_CLK);
         got = 2'h0;
         repeat (12) begin
            @(posedge I_CLK);
            got = got | {O_REJECT, O_OP_VALID};
         end
         if (e != ANY) chk(got, e);
      end
   endtask
   task lf(input [7:0] op, input [23:0] ad, input [7:0] dt, input [5:0] n, input [1:0] e);
      begin
         f(8'h06, 24'h0, 8'h00, N1, ACC);
         f(op, ad, dt, n, e);
      end
   endtask
   task st(input [7:0] v);
      lf(8'h01, {v, 16'h0}, 8'h00, N2, ANY);
   endtask
   // =====================================
   // main sequence
   initial begin
      I_RST_B = 1'b0;
      I_WP_B = 1'b1;
      I_WR = 1'b0;
      I_RD = 1'b0;
      I_ADDR = 2'h0;
      I_WDATA = 8'h00;
      go = 1'b0;
      frm = 40'h0;
      nb = 6'h00;
      repeat (8) @(posedge I_CLK);
      I_RST_B <= 1'b1;
      repeat (4) @(posedge I_CLK);
      rdc(2'h0, 8'h00);
      rdc(2'h1, 8'h00);
      f(8'h06, 24'h0, 8'h00, N1, ACC);
      rdc(2'h0, 8'h02);
      f(8'h04, 24'h0, 8'h00, N1, ACC);
      chk(O_WRITE_ENABLE_LATCH, 0);
      f(8'h12, 24'h000100, 8'hAA, N5, REF);
      lf(8'h12, 24'h000100, 8'hAA, 6'h27, REF);
      rdc(2'h3, 8'h06);
      lf(8'h12, 24'h000100, 8'hAA, N5, RUN);
      chk({O_OP_CODE, O_OP_DATA}, 16'h12AA);
      chk(O_OP_ADDR, 24'h000100);
      chk(O_WRITE_ENABLE_LATCH, 0);
      for (k = 0; k < 6; k = k + 1) begin
         lf(ops[47 - 8 * k -: 8], 24'h010000, 8'h5A,
            (k < 2) ? N5 : (k == 5) ? N1 : N4, RUN);
         chk(O_WRITE_ENABLE_LATCH, 0);
         chk(O_OP_CODE, ops[47 - 8 * k -: 8]);
      end
      st(8'h04);
      rdc(2'h0, 8'h04);
      lf(8'h20, 24'hFE0000, 8'h00, N4, REF);
      lf(8'h20, 24'hFD0000, 8'h00, N4, RUN);
      lf(8'h15, 24'h0, 8'h00, N1, REF);
      st(8'h20);
      lf(8'h20, 24'h000000, 8'h00, N4, REF);
      st(8'hA0);
      rdc(2'h0, 8'hA0);
      I_WP_B <= 1'b0;
      st(8'h00);
      rdc(2'h0, 8'hA0);
      I_WP_B <= 1'b1;
      st(8'hC0);
      I_WP_B <= 1'b0;
      st(8'h00);
      rdc(2'h0, 8'h00);
      I_WP_B <= 1'b1;
      f(8'h1E, 24'h0, 8'h00, N1, ACC);
      rdc(2'h1, 8'h01);
      f(8'h06, 24'h0, 8'h00, N1, REF);
      f(8'h21, 24'h0, 8'h00, N1, ACC);
      f(8'h1F, 24'h0, 8'h00, N1, ACC);
      rdc(2'h1, 8'h00);
      f(8'h1B, 24'h0, 8'h00, N1, ANY);
      rdc(2'h1, 8'h02);
      lf(8'h12, 24'h000005, 8'h11, N5, REF);
      lf(8'h12, 24'h000010, 8'h22, N5, RUN);
      chk({O_OP_OTP, O_OP_ADDR}, {1'b1, 24'h000010});
      lf(8'h20, 24'h000000, 8'h00, N4, REF);
      f(8'h1C, 24'h0, 8'h00, N1, ANY);
      rdc(2'h1, 8'h00);
      lf(8'h1D, 24'h0, 8'h00, N1, ANY);
      rdc(2'h2, 8'h02);
      wr(2'h3, 8'h01);
      rdc(2'h2, 8'h03);
      wr(2'h3, 8'h00);
      rdc(2'h2, 8'h03);
      f(8'h1B, 24'h0, 8'h00, N1, ANY);
      lf(8'h12, 24'h000020, 8'h33, N5, REF);
      f(8'h1C, 24'h0, 8'h00, N1, ANY);
      lf(8'h16, 24'h030000, 8'h00, N4, ANY);
      lf(8'h12, 24'h030000, 8'h44, N5, RUN);
      f(8'h1A, 24'h0, 8'h00, N1, REF);
      rdc(2'h1, 8'h00);
      wr(2'h3, 8'h02);
      rdc(2'h1, 8'h04);
      lf(8'h16, 24'h030000, 8'h00, N4, ACC);
      lf(8'h12, 24'h030000, 8'h44, N5, REF);
      lf(8'h12, 24'h040000, 8'h44, N5, RUN);
      lf(8'h16, 24'hFF0000, 8'h00, N4, ACC);
      lf(8'h12, 24'hFF1000, 8'h44, N5, RUN);
      lf(8'h17, 24'h030000, 8'h00, N4, ACC);
      lf(8'h12, 24'h030000, 8'h44, N5, RUN);
      lf(8'h18, 24'h0, 8'h00, N1, ACC);
      lf(8'h12, 24'h040000, 8'h44, N5, REF);
      lf(8'h19, 24'h0, 8'h00, N1, ACC);
      lf(8'h12, 24'h040000, 8'h44, N5, RUN);
      wrap_up;
   end
endmodule
